// file: cofg_far_model.sv
// far-side model: breaker close command and protection start lines
module cofg_far_model (
    // clock
    input wire logic clk,
    // commands from the bench
    input wire logic close_cmd,
    input wire logic [7:0] start_cmd,
    // lines toward the guard
    output logic close_line,
    output logic [7:0] start_lines
);
    timeunit 1ns;
    timeprecision 1ns;
    // lines move just after each rising edge and are held as levels
    always_ff @(posedge clk) begin
        close_line <= close_cmd;
        start_lines <= start_cmd;
    end
endmodule // cofg_far_model

// file: cofg_guard.sv
// close-onto-fault guard: arming window, instant trip, events and log
// ----------------------------------------------------------------
// Summary of operation
// ----------------------------------------------------------------
module cofg_guard
    import cofg_pkg::*;
#(
    parameter int unsigned REQ_N = NUM_REQ,
    parameter int unsigned MS_DIV = MS_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // binary inputs
    input wire logic arm_input,
    input wire logic inhibit_input,
    input wire logic [REQ_N-1:0] trip_request_input,
    // settings
    input wire logic [MS_W-1:0] release_time_setting,
    input wire logic [SG_W-1:0] setting_group_select,
    input wire logic force_enable,
    input wire logic [1:0] force_status,
    input wire logic [7:0] store_select,
    input wire logic counter_clear,
    input wire logic [TS_W-1:0] timestamp_ms,
    // outputs
    output logic armed_output,
    output logic trip_output,
    output logic [2:0] status_code,
    output logic [MS_W-1:0] time_remaining,
    output logic [MS_W-1:0] active_elapsed,
    // event stream
    output logic event_valid,
    output logic [EVT_W-1:0] event_code,
    output logic [TS_W-1:0] event_stamp,
    // counters
    output logic [CNT_W-1:0] init_count,
    output logic [CNT_W-1:0] block_count,
    output logic [CNT_W-1:0] active_count,
    output logic [CNT_W-1:0] trip_count,
    // record log read port
    input wire logic [3:0] log_index,
    output logic [TS_W-1:0] log_stamp,
    output logic [EVT_W-1:0] log_code,
    output logic [SG_W-1:0] log_group,
    output logic [MS_W-1:0] log_remaining,
    output logic [MS_W-1:0] log_elapsed,
    output logic [3:0] log_fill
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic arm_prev;
        logic armed;
        logic [31:0] div;
        logic [MS_W-1:0] remain;
        logic [MS_W-1:0] elapsed;
        logic [2:0] st;
        logic ev_v;
        logic [EVT_W-1:0] ev_c;
        logic [TS_W-1:0] ev_t;
        logic [CNT_W-1:0] c_init;
        logic [CNT_W-1:0] c_block;
        logic [CNT_W-1:0] c_act;
        logic [CNT_W-1:0] c_trip;
        logic [3:0] wptr;
        logic [3:0] fill;
    } cofg_state_t;

    typedef struct packed {
        logic [TS_W-1:0] t;
        logic [EVT_W-1:0] c;
        logic [SG_W-1:0] g;
        logic [MS_W-1:0] r;
        logic [MS_W-1:0] e;
    } cofg_rec_t;

    cofg_state_t s_reg, s_next;
    cofg_rec_t log_reg [LOG_DEPTH];
    logic log_we;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [MS_W-1:0] clamp_rel(input logic [MS_W-1:0] v);
        clamp_rel = (v > MS_W'(REL_MAX_MS)) ? MS_W'(REL_MAX_MS) : v;
    endfunction

    function automatic logic stored(input logic [1:0] sel, input logic on);
        stored = on ? sel[0] : sel[1];
    endfunction

    logic req_any;
    logic arm_edge;
    logic ms_tick;
    logic [2:0] raw_st;
    logic [3:0] ev_on;
    logic [3:0] ev_off;
    logic [3:0] st_flags_now;
    logic [3:0] st_flags_old;

    assign req_any = |trip_request_input;
    assign arm_edge = arm_input & ~s_reg.arm_prev;
    assign ms_tick = (s_reg.div == MS_DIV - 1);

    function automatic logic [3:0] flags(input logic [2:0] st);
        flags = {st == ST_TRIP, st == ST_ACTIVE || st == ST_TRIP,
                 st == ST_BLOCKED, st == ST_INIT};
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        log_we = 1'b0;
        s_next.arm_prev = arm_input;
        s_next.div = ms_tick ? 32'h0 : s_reg.div + 32'h1;
        s_next.ev_v = 1'b0;
        if (inhibit_input) begin
            s_next.armed = 1'b0;
            s_next.remain = '0;
        end else if (arm_edge) begin
            s_next.armed = 1'b1;
            s_next.remain = clamp_rel(release_time_setting);
            s_next.elapsed = '0;
        end else if (s_reg.armed && ms_tick) begin
            if (s_reg.remain <= MS_W'(1)) begin
                s_next.armed = 1'b0;
                s_next.remain = '0;
            end else begin
                s_next.remain = s_reg.remain - MS_W'(1);
            end
            s_next.elapsed = s_reg.elapsed + MS_W'(1);
        end else if (s_reg.armed && s_reg.remain == '0) begin
            s_next.armed = 1'b0;
        end
        // status
        raw_st = ST_NORMAL;
        if (inhibit_input) begin
            raw_st = ST_BLOCKED;
        end else if (s_next.armed && req_any) begin
            raw_st = ST_TRIP;
        end else if (s_next.armed) begin
            raw_st = ST_ACTIVE;
        end
        if (force_enable) begin
            unique case (force_status)
                FORCE_NORMAL: raw_st = ST_NORMAL;
                FORCE_BLOCKED: raw_st = ST_BLOCKED;
                FORCE_ACTIVE: raw_st = ST_ACTIVE;
                FORCE_TRIP: raw_st = ST_TRIP;
            endcase
        end
        if (arm_edge && raw_st == ST_ACTIVE) begin
            raw_st = ST_INIT;
        end
        s_next.st = raw_st;
        // events: index 0 init, 1 block, 2 active, 3 trip
        st_flags_now = flags(raw_st);
        st_flags_old = flags(s_reg.st);
        ev_on = st_flags_now & ~st_flags_old;
        ev_off = ~st_flags_now & st_flags_old;
        for (int i = 0; i < 4; i++) begin
            if (ev_on[i] && stored(store_select[2*i +: 2], 1'b1)) begin
                s_next.ev_v = 1'b1;
                s_next.ev_c = EVT_W'(2 * i);
                s_next.ev_t = timestamp_ms;
            end else if (ev_off[i] &&
                         stored(store_select[2*i +: 2], 1'b0)) begin
                s_next.ev_v = 1'b1;
                s_next.ev_c = EVT_W'(2 * i + 1);
                s_next.ev_t = timestamp_ms;
            end
        end
        // counters
        if (counter_clear) begin
            s_next.c_init = '0;
            s_next.c_block = '0;
            s_next.c_act = '0;
            s_next.c_trip = '0;
        end
        if (ev_on[0]) s_next.c_init = s_next.c_init + CNT_W'(1);
        if (ev_on[1]) s_next.c_block = s_next.c_block + CNT_W'(1);
        if (ev_on[2]) s_next.c_act = s_next.c_act + CNT_W'(1);
        if (ev_on[3]) s_next.c_trip = s_next.c_trip + CNT_W'(1);
        // log on active on
        if (ev_on[2]) begin
            log_we = 1'b1;
            s_next.wptr = (s_reg.wptr == 4'(LOG_DEPTH - 1)) ?
                          4'h0 : s_reg.wptr + 4'h1;
            if (s_reg.fill != 4'(LOG_DEPTH)) begin
                s_next.fill = s_reg.fill + 4'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_reg <= '0;
            s_reg.arm_prev <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    always_ff @(posedge clk) begin
        if (log_we) begin
            log_reg[s_reg.wptr] <= '{t: timestamp_ms, c: EV_ACT_ON,
                g: setting_group_select, r: s_next.remain,
                e: s_next.elapsed};
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign status_code = s_reg.st;
    assign armed_output = (s_reg.st == ST_ACTIVE) || (s_reg.st == ST_INIT)
                          || (s_reg.st == ST_TRIP);
    // trip is combinational so a request trips in the same cycle
    assign trip_output = (force_enable && force_status == FORCE_TRIP) ||
        (!force_enable && s_reg.armed && !inhibit_input && req_any);
    assign time_remaining = s_reg.remain;
    assign active_elapsed = s_reg.elapsed;
    assign event_valid = s_reg.ev_v;
    assign event_code = s_reg.ev_c;
    assign event_stamp = s_reg.ev_t;
    assign init_count = s_reg.c_init;
    assign block_count = s_reg.c_block;
    assign active_count = s_reg.c_act;
    assign trip_count = s_reg.c_trip;
    assign log_fill = s_reg.fill;

    always_comb begin
        if (log_index < 4'(LOG_DEPTH) && log_index < s_reg.fill) begin
            log_stamp = log_reg[log_index].t;
            log_code = log_reg[log_index].c;
            log_group = log_reg[log_index].g;
            log_remaining = log_reg[log_index].r;
            log_elapsed = log_reg[log_index].e;
        end else begin
            log_stamp = '0;
            log_code = '0;
            log_group = '0;
            log_remaining = '0;
            log_elapsed = '0;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_arm_edge_only: assert property (@(posedge clk) disable iff (!reset_n)
        (!s_reg.armed && !arm_edge) |=> !s_reg.armed)
        else $error("armed without rising edge");
    a_trip_instant: assert property (@(posedge clk) disable iff (!reset_n)
        (s_reg.armed && req_any && !inhibit_input && !force_enable)
        |-> trip_output)
        else $error("trip not immediate");
    a_no_trip_idle: assert property (@(posedge clk) disable iff (!reset_n)
        (!s_reg.armed && !force_enable) |-> !trip_output)
        else $error("trip outside window");
    a_inhibit_blocks: assert property (@(posedge clk) disable iff (!reset_n)
        inhibit_input |=> !s_reg.armed)
        else $error("window started while inhibited");
    a_rearm_reload: assert property (@(posedge clk) disable iff (!reset_n)
        (arm_edge && !inhibit_input) |=>
        s_reg.remain == clamp_rel($past(release_time_setting)))
        else $error("release time not reloaded");
    a_remain_limit: assert property (@(posedge clk) disable iff (!reset_n)
        s_reg.remain <= MS_W'(REL_MAX_MS))
        else $error("remaining time above limit");
    a_force_status: assert property (@(posedge clk) disable iff (!reset_n)
        (force_enable && force_status == FORCE_BLOCKED && !arm_edge)
        |=> status_code == ST_BLOCKED)
        else $error("forced status ignored");
    a_count_trip: assert property (@(posedge clk) disable iff (!reset_n)
        (ev_on[3] && !counter_clear) |=>
        trip_count == $past(trip_count) + CNT_W'(1))
        else $error("trip counter missed event");
    a_log_fill: assert property (@(posedge clk) disable iff (!reset_n)
        s_reg.fill <= 4'(LOG_DEPTH))
        else $error("log overfilled");
endmodule // cofg_guard

// file: cofg_pkg.sv
// package of constants and types for the close-onto-fault guard
package cofg_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned MS_TICK_NS = 1_000_000;
    localparam int unsigned CLK_NS = 10;
    localparam int unsigned MS_CYCLES = MS_TICK_NS / CLK_NS;
    localparam int unsigned REL_MAX_MS = 1_800_000;
    localparam logic [20:0] REL_DEFAULT_MS = 21'h0003E8;
    localparam int unsigned LOG_DEPTH = 12;
    localparam int unsigned NUM_REQ = 8;
    localparam int unsigned EVT_W = 3;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned SG_W = 3;
    localparam int unsigned TS_W = 48;
    localparam int unsigned MS_W = 21;
    // event codes, one per transition
    localparam logic [2:0] EV_INIT_ON = 3'h0;
    localparam logic [2:0] EV_INIT_OFF = 3'h1;
    localparam logic [2:0] EV_BLOCK_ON = 3'h2;
    localparam logic [2:0] EV_BLOCK_OFF = 3'h3;
    localparam logic [2:0] EV_ACT_ON = 3'h4;
    localparam logic [2:0] EV_ACT_OFF = 3'h5;
    localparam logic [2:0] EV_TRIP_ON = 3'h6;
    localparam logic [2:0] EV_TRIP_OFF = 3'h7;
    // forced status codes
    localparam logic [1:0] FORCE_NORMAL = 2'h0;
    localparam logic [1:0] FORCE_BLOCKED = 2'h1;
    localparam logic [1:0] FORCE_ACTIVE = 2'h2;
    localparam logic [1:0] FORCE_TRIP = 2'h3;
    // event store selection
    localparam logic [1:0] STORE_NONE = 2'h0;
    localparam logic [1:0] STORE_ON = 2'h1;
    localparam logic [1:0] STORE_OFF = 2'h2;
    localparam logic [1:0] STORE_BOTH = 2'h3;

    typedef enum logic [2:0] {
        ST_NORMAL = 3'h0,
        ST_INIT = 3'h1,
        ST_ACTIVE = 3'h2,
        ST_TRIP = 3'h3,
        ST_BLOCKED = 3'h4
    } cofg_status_t;
endpackage

// file: tb_switch_on_to_fault_arming.sv
// self-checking bench for the close-onto-fault guard
module tb_switch_on_to_fault_arming import cofg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk = 1'b0;
    logic reset_n, close_cmd, arm_line, inhibit, force_en, clr;
    logic [7:0] start_cmd, req_lines, store_sel;
    logic [20:0] rel_set, remain, elapsed, l_rem, l_el;
    logic [2:0] sg, status, ev_code, l_code, l_group;
    logic [1:0] force_st;
    logic [47:0] ts = 48'h0;
    logic [47:0] ev_stamp, l_stamp;
    logic [3:0] log_idx, l_fill;
    logic armed, trip, ev_valid;
    logic [15:0] c_init, c_block, c_act, c_trip;
    int fails = 0;
    int checks = 0;
    int n_init = 0;
    int n_trip = 0;
    int k;
    // rows: expected trip above the start pattern
    logic [8:0] rows [10] = '{9'h101, 9'h102, 9'h104, 9'h108, 9'h110,
                              9'h120, 9'h140, 9'h180, 9'h000, 9'h1A5};
    logic [2:0] f_stat [4] = '{3'h0, 3'h4, 3'h2, 3'h3};

    cofg_far_model far (.clk(clk), .close_cmd(close_cmd),
        .start_cmd(start_cmd), .close_line(arm_line),
        .start_lines(req_lines));

    cofg_guard #(.REQ_N(8), .MS_DIV(10)) dut (.clk(clk), .reset_n(reset_n),
        .arm_input(arm_line), .inhibit_input(inhibit),
        .trip_request_input(req_lines), .release_time_setting(rel_set),
        .setting_group_select(sg), .force_enable(force_en),
        .force_status(force_st), .store_select(store_sel),
        .counter_clear(clr), .timestamp_ms(ts), .armed_output(armed),
        .trip_output(trip), .status_code(status), .time_remaining(remain),
        .active_elapsed(elapsed), .event_valid(ev_valid),
        .event_code(ev_code), .event_stamp(ev_stamp), .init_count(c_init),
        .block_count(c_block), .active_count(c_act), .trip_count(c_trip),
        .log_index(log_idx), .log_stamp(l_stamp), .log_code(l_code),
        .log_group(l_group), .log_remaining(l_rem), .log_elapsed(l_el),
        .log_fill(l_fill));

    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        ts <= ts + 48'h1;
    end
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic nx(input int n);
        repeat (n) @(posedge clk);
    endtask
    // low then high on the close line; checks the init and active steps
    task automatic arm(input logic blk, input logic stored,
                       input logic [20:0] exp_rem);
        logic was;
        was = armed;
        nx(1);
        close_cmd <= 1'b0;
        nx(3);
        close_cmd <= 1'b1;
        nx(2);
        @(negedge clk);
        chk(status, blk ? 3'h4 : 3'h1);
        chk(armed, !blk);
        chk(ev_valid, stored && !blk);
        if (!blk) begin
            n_init++;
            chk(remain, exp_rem);
            // re-arm: active off outranks init on
            if (stored) begin
                chk(ev_code, was ? EV_ACT_OFF : EV_INIT_ON);
                chk(ev_stamp, ts - 48'h1);
            end
        end
        @(negedge clk);
        chk(status, blk ? 3'h4 : 3'h2);
        if (stored && !blk) chk(ev_code, EV_ACT_ON);
        chk(c_init, n_init);
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        reset_n = 1'b0; close_cmd = 1'b0; inhibit = 1'b0; force_en = 1'b0;
        clr = 1'b0; start_cmd = 8'h00; store_sel = 8'hFF; rel_set = 21'h5;
        sg = 3'h5; force_st = FORCE_NORMAL; log_idx = 4'h0;
        nx(5);
        reset_n <= 1'b1;
        @(negedge clk);
        chk({armed, trip, status, l_fill}, 9'h000);
        chk({c_init, c_block, c_act, c_trip}, 64'h0);
        for (int i = 0; i < 10; i++) begin
            arm(1'b0, 1'b1, 21'h5);
            nx(1);
            start_cmd <= rows[i][7:0];
            nx(1);
            @(negedge clk);
            chk(trip, rows[i][8]);
            @(negedge clk);
            chk(status, rows[i][8] ? 3'h3 : 3'h2);
            n_trip += rows[i][8];
            nx(1);
            start_cmd <= 8'h00;
            nx(2);
            @(negedge clk);
            chk(c_trip, n_trip);
        end
        arm(1'b0, 1'b1, 21'h5);
        k = 0;
        while (armed === 1'b1 && k < 80) begin
            @(negedge clk);
            k++;
        end
        if (k >= 80) begin
            fails++;
            report_and_stop();
        end
        chk(k >= 37 && k <= 52, 1'b1);
        chk({remain, elapsed}, {21'h0, 21'h5});
        nx(1);
        start_cmd <= 8'hFF;
        nx(1);
        @(negedge clk);
        chk(trip, 1'b0);
        nx(40);
        @(negedge clk);
        chk({armed, c_init}, {1'b0, 16'(n_init)});
        nx(1);
        start_cmd <= 8'h00;
        arm(1'b0, 1'b1, 21'h5);
        nx(15);
        arm(1'b0, 1'b1, 21'h5);
        nx(35);
        @(negedge clk);
        chk(armed, 1'b1);
        rel_set <= 21'h1FFFFF;
        arm(1'b0, 1'b1, 21'(REL_MAX_MS));
        rel_set <= 21'h5;
        store_sel <= 8'h00;
        arm(1'b0, 1'b0, 21'h5);
        store_sel <= 8'hFF;
        nx(1);
        clr <= 1'b1;
        nx(1);
        clr <= 1'b0;
        @(negedge clk);
        chk({c_init, c_block, c_act, c_trip}, 64'h0);
        n_init = 0;
        nx(1);
        inhibit <= 1'b1;
        nx(2);
        @(negedge clk);
        chk({status, armed}, {3'h4, 1'b0});
        arm(1'b1, 1'b1, 21'h5);
        chk(c_block, 16'h1);
        nx(1);
        inhibit <= 1'b0;
        force_en <= 1'b1;
        for (int f = 0; f < 4; f++) begin
            nx(1);
            force_st <= 2'(f);
            nx(2);
            @(negedge clk);
            chk(status, f_stat[f]);
            chk(trip, f == 3);
        end
        nx(1);
        force_en <= 1'b0;
        force_st <= FORCE_NORMAL;
        @(negedge clk);
        chk(l_fill, 4'hC);
        chk({l_code, l_group}, {EV_ACT_ON, sg});
        nx(1);
        reset_n <= 1'b0;
        nx(2);
        reset_n <= 1'b1;
        @(negedge clk);
        chk({status, l_fill, c_init}, 23'h0);
        nx(3);
        @(negedge clk);
        chk(armed, 1'b0);
        arm(1'b0, 1'b1, 21'h5);
        chk(l_stamp, ts - 48'h1);
        chk({l_code, l_group, l_fill}, {EV_ACT_ON, sg, 4'h1});
        chk(l_rem + l_el, 21'h5);
        report_and_stop();
    end
endmodule // tb_switch_on_to_fault_arming
